// >>> design/shx_pkg.sv
// Package: register map, command fields and encodings of the shift-with-extension datapath
package shx_pkg;

	// ==========================================================
	// Datapath geometry
	localparam int SHX_W = 32;
	localparam int SHX_CNT_W = 5;

	// ==========================================================
	// Register byte offsets (haddr[7:0])
	localparam logic [7:0] SHX_OFS_SOURCE = 8'h00;
	localparam logic [7:0] SHX_OFS_AMOUNT = 8'h04;
	localparam logic [7:0] SHX_OFS_EXT = 8'h08;
	localparam logic [7:0] SHX_OFS_CMD = 8'h0c;
	localparam logic [7:0] SHX_OFS_DEST = 8'h10;
	localparam logic [7:0] SHX_OFS_COND = 8'h14;
	localparam logic [7:0] SHX_OFS_STATUS = 8'h18;
	localparam int SHX_DEC_W = 8;

	// ==========================================================
	// Command word fields
	localparam int SHX_CMD_OP_LSB = 0;
	localparam int SHX_CMD_OP_W = 3;
	localparam int SHX_CMD_CNT_LSB = 3;
	localparam int SHX_CMD_REC_BIT = 8;
	localparam int SHX_CMD_SO_BIT = 9;
	localparam int SHX_CMD_W = 10;

	// Amount word fields: big-endian bits 27-31 and 26
	localparam int SHX_AMT_CNT_LSB = 0;
	localparam int SHX_AMT_SEL_BIT = 5;

	// Condition field layout: {lt, gt, eq, so}
	localparam int SHX_COND_W = 4;
	localparam int SHX_COND_LT = 3;
	localparam int SHX_COND_GT = 2;
	localparam int SHX_COND_EQ = 1;
	localparam int SHX_COND_SO = 0;

	// Status word fields
	localparam int SHX_STAT_BAD_BIT = 0;
	localparam int SHX_STAT_CNT_LSB = 16;
	localparam int SHX_STAT_CNT_W = 16;

	// ==========================================================
	// Reset values
	localparam logic [31:0] SHX_RST_WORD = 32'h0000_0000;
	localparam logic [3:0] SHX_RST_COND = 4'h0;
	localparam logic [15:0] SHX_RST_OPS = 16'h0000;

	// Read access: cycles of wait state inserted per read
	localparam int SHX_READ_WAIT = 1;

	// ==========================================================
	// Operation codes carried in the command word
	typedef enum logic [2:0] {
		SHX_OP_SHL_IMM = 3'h0,
		SHX_OP_SHR_IMM = 3'h1,
		SHX_OP_SHL_LONG_IMM = 3'h2,
		SHX_OP_SHR_LONG_IMM = 3'h3,
		SHX_OP_SHL_LONG_REG = 3'h4
	} shx_op_t;

	// AHB-Lite transfer codes and response
	localparam logic [1:0] SHX_HTRANS_NONSEQ = 2'h2;
	localparam logic SHX_HRESP_OKAY = 1'b0;

endpackage

// >>> design/shx_rotmask.sv
// Rotator and mask generator for one shift count
`timescale 1ns/1ps
`default_nettype none
module shx_rotmask #(
	parameter int W = 32,
	parameter int CW = 5
) (
	input wire logic [W-1:0] word,
	input wire logic [CW-1:0] amount,
	input wire logic dir_right,
	output logic [W-1:0] rot,
	output logic [W-1:0] mask_left,
	output logic [W-1:0] mask_right
);

	// ==========================================================
	// Elaboration check
	initial begin
		if ((1 << CW) != W)
			$error("shx_rotmask: W must equal 2**CW");
	end

	logic [2*W-1:0] dbl_left;
	logic [2*W-1:0] dbl_right;

	// Doubled word turns a shift into a rotate; right by n equals left by W-n
	always_comb begin
		dbl_left = {word, word} << amount;
		dbl_right = {word, word} >> amount;
		rot = dir_right ? dbl_right[W-1:0] : dbl_left[2*W-1:W];
	end

	// Ones then n zeros, and n zeros then ones, high bit first
	assign mask_left = {W{1'b1}} << amount;
	assign mask_right = {W{1'b1}} >> amount;

endmodule // shx_rotmask
`default_nettype wire

// >>> design/shx_unit.sv
// Shift-with-extension datapath slice behind an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Left immediate: rotate left, extension gets rotated
// - Left immediate: destination is rotated AND left mask
// - Right immediate: rotate left 32-n into extension
// - Right immediate: destination is rotated AND right mask
// - Long left immediate: merge rotated with extension
// - Long left immediate: destination merged, extension rotated
// - Long right immediate: merge, destination, extension rotated
// - Register long left: count from amount bits 27-31
// - Amount bit 26 zero: left mask merge
// - Amount bit 26 one: zeros merged, inverse mask
// - Condition field changes only on recording forms
// - Recording sets condition from destination value
// - Register long left keeps extension unchanged
module shx_unit
#(
	parameter int W = shx_pkg::SHX_W,
	parameter int CW = shx_pkg::SHX_CNT_W
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	import shx_pkg::*;

	// ==========================================================
	// Elaboration check: fields and bus word are fixed at 32 bits
	initial begin
		if (W != SHX_W || CW != SHX_CNT_W)
			$error("shx_unit: only a 32-bit datapath with 5-bit count is supported");
	end

	// ==========================================================
	// Architectural state
	logic [W-1:0] source_gpr, amount_gpr;
	logic [W-1:0] extension_word_register;
	logic [W-1:0] destination_gpr;
	logic [SHX_COND_W-1:0] first_condition_field;
	logic [SHX_CMD_W-1:0] last_cmd;
	logic bad_cmd;
	logic [SHX_STAT_CNT_W-1:0] ops_done;

	// Bus pipeline state
	logic dp_write, dp_read;
	logic [SHX_DEC_W-1:0] dp_addr;
	logic read_wait;

	// Execute path
	logic exec;
	shx_op_t op;
	logic [CW-1:0] immediate_shift_count;
	logic [CW-1:0] shift_n;
	logic amount_sel;
	logic record, so_in;
	logic dir_right;
	logic [W-1:0] rot, mask_left, mask_right;
	logic [W-1:0] next_dest, next_ext;
	logic next_bad;
	logic [SHX_COND_W-1:0] next_cond;
	logic [31:0] next_rdata;

	// ==========================================================
	// Mask-controlled merge
	function automatic logic [W-1:0] shx_merge(
		input logic [W-1:0] cand,
		input logic [W-1:0] ext,
		input logic [W-1:0] mask
	);
		shx_merge = (cand & mask) | (ext & ~mask);
	endfunction

	// ==========================================================
	// AHB-Lite address phase capture
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= '0;
		end else if (hready) begin
			dp_write <= hsel && htrans == SHX_HTRANS_NONSEQ && hwrite;
			dp_read <= hsel && htrans == SHX_HTRANS_NONSEQ && !hwrite;
			dp_addr <= haddr[SHX_DEC_W-1:0];
		end
	end

	// One wait state on reads so a write just ahead is always seen
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			read_wait <= 1'b0;
		end else begin
			read_wait <= dp_read && !read_wait;
		end
	end

	assign hreadyout = !(dp_read && !read_wait);
	assign hresp = SHX_HRESP_OKAY;

	// ==========================================================
	// Command decode: a write to the command word runs one operation
	assign exec = dp_write && dp_addr == SHX_OFS_CMD;
	assign op = shx_op_t'(hwdata[SHX_CMD_OP_LSB +: SHX_CMD_OP_W]);
	assign immediate_shift_count = hwdata[SHX_CMD_CNT_LSB +: CW];
	assign record = hwdata[SHX_CMD_REC_BIT];
	assign so_in = hwdata[SHX_CMD_SO_BIT];
	assign amount_sel = amount_gpr[SHX_AMT_SEL_BIT];

	// Count source: register form reads the amount word instead
	assign shift_n = (op == SHX_OP_SHL_LONG_REG) ?
		amount_gpr[SHX_AMT_CNT_LSB +: CW] : immediate_shift_count;
	assign dir_right = op == SHX_OP_SHR_IMM || op == SHX_OP_SHR_LONG_IMM;

	shx_rotmask #(
		.W(W),
		.CW(CW)
	) u_rotmask (
		.word(source_gpr),
		.amount(shift_n),
		.dir_right(dir_right),
		.rot(rot),
		.mask_left(mask_left),
		.mask_right(mask_right)
	);

	// ==========================================================
	// Result select per operation
	always_comb begin
		next_dest = destination_gpr;
		next_ext = extension_word_register;
		next_bad = 1'b0;
		case (op)
			SHX_OP_SHL_IMM: begin
				next_dest = rot & mask_left;
				next_ext = rot;
			end
			SHX_OP_SHR_IMM: begin
				next_dest = rot & mask_right;
				next_ext = rot;
			end
			SHX_OP_SHL_LONG_IMM: begin
				next_dest = shx_merge(rot, extension_word_register, mask_left);
				next_ext = rot;
			end
			SHX_OP_SHR_LONG_IMM: begin
				next_dest = shx_merge(rot, extension_word_register, mask_right);
				next_ext = rot;
			end
			SHX_OP_SHL_LONG_REG: begin
				if (!amount_sel) begin
					next_dest = shx_merge(rot, extension_word_register, mask_left);
				end else begin
					next_dest = shx_merge('0, extension_word_register, ~mask_left);
				end
				next_ext = extension_word_register;
			end
			default: begin
				next_bad = 1'b1;
			end
		endcase
	end

	// Signed compare of the new destination value
	always_comb begin
		next_cond[SHX_COND_LT] = next_dest[W-1];
		next_cond[SHX_COND_GT] = !next_dest[W-1] && next_dest != '0;
		next_cond[SHX_COND_EQ] = next_dest == '0;
		next_cond[SHX_COND_SO] = so_in;
	end

	// ==========================================================
	// Operand registers, written by software only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			source_gpr <= SHX_RST_WORD;
			amount_gpr <= SHX_RST_WORD;
		end else if (dp_write) begin
			if (dp_addr == SHX_OFS_SOURCE)
				source_gpr <= hwdata;
			if (dp_addr == SHX_OFS_AMOUNT)
				amount_gpr <= hwdata;
		end
	end

	// Extension word: software load, or the executing operation
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			extension_word_register <= SHX_RST_WORD;
		end else if (dp_write && dp_addr == SHX_OFS_EXT) begin
			extension_word_register <= hwdata;
		end else if (exec) begin
			extension_word_register <= next_ext;
		end
	end

	// Destination result
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			destination_gpr <= SHX_RST_WORD;
		end else if (exec) begin
			destination_gpr <= next_dest;
		end
	end

	// Condition field: untouched by non-recording forms and bad codes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			first_condition_field <= SHX_RST_COND;
		end else if (exec && record && !next_bad) begin
			first_condition_field <= next_cond;
		end
	end

	// Command echo, bad-code flag and operation counter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			last_cmd <= '0;
			bad_cmd <= 1'b0;
			ops_done <= SHX_RST_OPS;
		end else if (exec) begin
			last_cmd <= hwdata[SHX_CMD_W-1:0];
			bad_cmd <= next_bad;
			if (!next_bad)
				ops_done <= ops_done + 1'b1;
		end
	end

	// ==========================================================
	// Read mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = '0;
		case (dp_addr)
			SHX_OFS_SOURCE: next_rdata = source_gpr;
			SHX_OFS_AMOUNT: next_rdata = amount_gpr;
			SHX_OFS_EXT: next_rdata = extension_word_register;
			SHX_OFS_CMD: next_rdata[SHX_CMD_W-1:0] = last_cmd;
			SHX_OFS_DEST: next_rdata = destination_gpr;
			SHX_OFS_COND: next_rdata[SHX_COND_W-1:0] = first_condition_field;
			SHX_OFS_STATUS: begin
				next_rdata[SHX_STAT_BAD_BIT] = bad_cmd;
				next_rdata[SHX_STAT_CNT_LSB +: SHX_STAT_CNT_W] = ops_done;
			end
			default: next_rdata = '0;
		endcase
	end

	// Read data loaded in the wait cycle, held until the next read
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hrdata <= '0;
		end else if (dp_read && !read_wait) begin
			hrdata <= next_rdata;
		end
	end

	// ==========================================================
	// Reference model helpers, read only by the checks below
	logic [W-1:0] ref_rotl, ref_rotr, ref_lmask, ref_rmask;
	logic [5:0] ref_inv;
	logic ex_shl, ex_shr, ex_shll, ex_shrl, ex_reg;

	assign ref_inv = 6'd32 - {1'b0, shift_n};
	assign ref_rotl = (source_gpr << shift_n) | (source_gpr >> ref_inv);
	assign ref_rotr = (source_gpr << ref_inv) | (source_gpr >> shift_n);
	assign ref_lmask = ~((32'h0000_0001 << shift_n) - 32'h0000_0001);
	assign ref_rmask = {<<{ref_lmask}}; // Mirrored left mask, built apart from the rotator
	assign ex_shl = exec && op == SHX_OP_SHL_IMM;
	assign ex_shr = exec && op == SHX_OP_SHR_IMM;
	assign ex_shll = exec && op == SHX_OP_SHL_LONG_IMM;
	assign ex_shrl = exec && op == SHX_OP_SHR_LONG_IMM;
	assign ex_reg = exec && op == SHX_OP_SHL_LONG_REG;

	// ==========================================================
	// Checks
	property p_shl_ext;
		@(posedge core_clk) disable iff (rst)
		ex_shl |=> extension_word_register == $past(ref_rotl);
	endproperty
	a_shl_ext: assert property (p_shl_ext) else $error("left form extension wrong");

	property p_shl_dest;
		@(posedge core_clk) disable iff (rst)
		ex_shl |=> destination_gpr == ($past(ref_rotl) & $past(ref_lmask));
	endproperty
	a_shl_dest: assert property (p_shl_dest) else $error("left form result wrong");

	property p_shr_ext;
		@(posedge core_clk) disable iff (rst)
		ex_shr |=> extension_word_register == $past(ref_rotr);
	endproperty
	a_shr_ext: assert property (p_shr_ext) else $error("right form extension wrong");

	property p_shr_dest;
		@(posedge core_clk) disable iff (rst)
		ex_shr |=> destination_gpr == ($past(ref_rotr) & $past(ref_rmask));
	endproperty
	a_shr_dest: assert property (p_shr_dest) else $error("right form result wrong");

	property p_shll;
		@(posedge core_clk) disable iff (rst)
		ex_shll |=> destination_gpr == (($past(ref_rotl) & $past(ref_lmask)) |
			($past(extension_word_register) & ~$past(ref_lmask))) &&
			extension_word_register == $past(ref_rotl);
	endproperty
	a_shll: assert property (p_shll) else $error("long left immediate wrong");

	property p_shrl;
		@(posedge core_clk) disable iff (rst)
		ex_shrl |=> destination_gpr == (($past(ref_rotr) & $past(ref_rmask)) |
			($past(extension_word_register) & ~$past(ref_rmask))) &&
			extension_word_register == $past(ref_rotr);
	endproperty
	a_shrl: assert property (p_shrl) else $error("long right immediate wrong");

	property p_reg_sel0;
		@(posedge core_clk) disable iff (rst)
		ex_reg && !amount_sel |=> destination_gpr == (($past(ref_rotl) & $past(ref_lmask)) |
			($past(extension_word_register) & ~$past(ref_lmask)));
	endproperty
	a_reg_sel0: assert property (p_reg_sel0) else $error("register form merge wrong");

	property p_reg_sel1;
		@(posedge core_clk) disable iff (rst)
		ex_reg && amount_sel |=>
			destination_gpr == ($past(extension_word_register) & $past(ref_lmask));
	endproperty
	a_reg_sel1: assert property (p_reg_sel1) else $error("register form zero merge wrong");

	property p_reg_ext;
		@(posedge core_clk) disable iff (rst)
		ex_reg |=> $stable(extension_word_register);
	endproperty
	a_reg_ext: assert property (p_reg_ext) else $error("register form altered extension");

	property p_norec;
		@(posedge core_clk) disable iff (rst)
		exec && !record |=> $stable(first_condition_field);
	endproperty
	a_norec: assert property (p_norec) else $error("condition changed without record");

	property p_rec;
		@(posedge core_clk) disable iff (rst)
		exec && record && !next_bad |=>
			first_condition_field[SHX_COND_EQ] == (destination_gpr == 32'h0000_0000) &&
			first_condition_field[SHX_COND_LT] == destination_gpr[31];
	endproperty
	a_rec: assert property (p_rec) else $error("condition not from result");

	property p_read_wait;
		@(posedge core_clk) disable iff (rst)
		hready && hsel && htrans == SHX_HTRANS_NONSEQ && !hwrite |=>
			!hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule // shx_unit
`default_nettype wire

// >>> verification/shx_unit_bench.sv
// Self-checking bench for the shift-with-extension register slave
`timescale 1ns/1ps
`default_nettype none
module shx_unit_bench;
	import shx_pkg::*;
	// ==========================================================
	// Clock, reset and bus signals
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	int fails = 0;
	int tests_run = 0;
	// Bench copies of the visible state
	logic [31:0] m_ext = 32'h0000_0000;
	logic [31:0] m_dest = 32'h0000_0000;
	logic [3:0] m_cond = 4'h0;
	logic [15:0] m_ops = 16'h0000;

	// Free-running 100 MHz clock
	always #5 core_clk = ~core_clk;
	// One slave only, so its ready is the bus ready
	assign hready = hreadyout;

	shx_unit dut (
		.core_clk(core_clk),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata)
	);

	// ==========================================================
	// Verdict and comparison
	task automatic give_verdict;
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ==========================================================
	// Bus master; entered just after a rising edge
	task automatic wait_rdy(output int i);
		i = 0;
		@(posedge core_clk);
		// Bounded so a stuck slave ends the run instead of hanging it
		while (hreadyout !== 1'b1 && i < 50) begin
			@(posedge core_clk);
			i++;
		end
		if (i >= 50) begin
			fails++;
			give_verdict();
		end
	endtask

	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
			output logic [31:0] rd);
		int waits;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= SHX_HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy(waits);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(waits);
		rd = hrdata;
		chk({31'h0, hresp}, {31'h0, SHX_HRESP_OKAY});
		chk(waits, w ? 0 : SHX_READ_WAIT); // Writes take no wait state, reads one
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(a, 1'b1, d, x);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		xfer(a, 1'b0, 32'h0000_0000, x);
		chk(x, exp);
	endtask

	task automatic set_ext(input logic [31:0] v);
		wr(SHX_OFS_EXT, v);
		m_ext = v;
	endtask

	// ==========================================================
	// Reference model: left rotate, counts 0 to 32
	function automatic logic [31:0] rotl(input logic [31:0] x, input int n);
		return (x << n) | (x >> (32 - n));
	endfunction

	// Loads operands, issues one command, checks every result register
	task automatic run_op(input int op, input int n, input logic rec, input logic so,
			input logic [31:0] src, input logic [31:0] amt);
		logic [31:0] r, lm, rm, d, e;
		int k;
		k = (op == 4) ? int'(amt[4:0]) : n;
		r = rotl(src, (op == 1 || op == 3) ? 32 - k : k);
		lm = 32'hffff_ffff << k;
		rm = 32'hffff_ffff >> k;
		e = r;
		case (op)
			0: d = r & lm;
			1: d = r & rm;
			2: d = (r & lm) | (m_ext & ~lm);
			3: d = (r & rm) | (m_ext & ~rm);
			default: begin
				d = amt[5] ? (m_ext & lm) : ((r & lm) | (m_ext & ~lm));
				e = m_ext;
			end
		endcase
		wr(SHX_OFS_SOURCE, src);
		wr(SHX_OFS_AMOUNT, amt);
		wr(SHX_OFS_CMD, {22'h0, so, rec, n[4:0], op[2:0]});
		m_ext = e;
		m_dest = d;
		m_ops++;
		if (rec) begin
			m_cond = {d[31], !d[31] && d != 32'h0, d == 32'h0, so};
		end
		rdc(SHX_OFS_DEST, m_dest);
		rdc(SHX_OFS_EXT, m_ext);
		rdc(SHX_OFS_COND, {28'h0, m_cond});
		rdc(SHX_OFS_STATUS, {m_ops, 16'h0000});
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rdc(SHX_OFS_SOURCE, SHX_RST_WORD);
		rdc(SHX_OFS_AMOUNT, SHX_RST_WORD);
		rdc(SHX_OFS_EXT, SHX_RST_WORD);
		rdc(SHX_OFS_DEST, SHX_RST_WORD);
		rdc(SHX_OFS_COND, {28'h0, SHX_RST_COND});
		rdc(SHX_OFS_STATUS, SHX_RST_WORD);
		rdc(8'h1c, 32'h0000_0000);
	endtask

	// Negative, zero and positive results, sticky bit both ways
	task automatic t_record;
		set_ext(32'h0000_0000);
		run_op(0, 4, 1'b1, 1'b1, 32'h0800_0000, 32'h0);
		run_op(0, 4, 1'b1, 1'b0, 32'h0000_0000, 32'h0);
		run_op(1, 28, 1'b1, 1'b1, 32'h1000_0000, 32'h0);
	endtask

	// Every immediate form at both count limits; condition must not move
	task automatic t_imm;
		int cnts [4] = '{0, 1, 17, 31};
		for (int op = 0; op < 4; op++) begin
			for (int i = 0; i < 4; i++) begin
				set_ext(32'hc3a5_0f96 ^ i);
				run_op(op, cnts[i], 1'b0, 1'b1, 32'h8123_4567 + op, 32'h0);
			end
		end
	endtask

	// Amount-register form, both selects; immediate field must be ignored
	task automatic t_reg;
		int cnts [3] = '{0, 5, 31};
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 3; i++) begin
				set_ext(32'h5a5a_f00f);
				run_op(4, 7, 1'b1, 1'b0, 32'h1234_abcd, {26'h0, s[0], cnts[i][4:0]});
			end
		end
	endtask

	// Bad opcodes change only the bad flag and command echo; a write to a read-only place changes nothing
	task automatic t_bad;
		for (int op = 5; op < 8; op++) begin
			wr(SHX_OFS_CMD, {22'h0, 1'b1, 1'b1, 5'h03, op[2:0]});
			rdc(SHX_OFS_STATUS, {m_ops, 16'h0001});
			rdc(SHX_OFS_CMD, {22'h0, 1'b1, 1'b1, 5'h03, op[2:0]});
			rdc(SHX_OFS_DEST, m_dest);
			rdc(SHX_OFS_EXT, m_ext);
			rdc(SHX_OFS_COND, {28'h0, m_cond});
		end
		wr(SHX_OFS_DEST, 32'hffff_ffff);
		rdc(SHX_OFS_DEST, m_dest);
		run_op(2, 9, 1'b1, 1'b1, 32'hf000_000f, 32'h0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_record();
		t_imm();
		t_reg();
		t_bad();
		give_verdict();
	end
endmodule // shx_unit_bench
`default_nettype wire
